// *** lasi_pkg.sv ***
package lasi_pkg;

   // host port register offsets
   localparam logic [7:0] ADDR_IDENTITY   = 8'h0f;
   localparam logic [7:0] ADDR_STATUS_A   = 8'h18;
   localparam logic [7:0] ADDR_MASK_A     = 8'h19;
   localparam logic [7:0] ADDR_STATUS_B   = 8'h1a;
   localparam logic [7:0] ADDR_MASK_B     = 8'h1b;
   localparam logic [7:0] ADDR_FRAME_EVT  = 8'h1c;
   localparam logic [7:0] ADDR_FRAME_MASK = 8'h1d;
   localparam logic [7:0] ADDR_COMMON_ONE = 8'h70;

   // field positions in common_control_one
   localparam int CCR_PIN_FUNC_BIT = 0;
   localparam int CCR_MCLK_SEL_BIT = 7;

   // value after reset and read value of unmapped addresses
   localparam logic [7:0] RESET_REG  = 8'h00;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;

   // carrier loss zero-run thresholds and clearing density
   localparam logic [11:0] ZEROS_E1_SHORT = 12'd255;
   localparam logic [11:0] ZEROS_E1_LONG  = 12'd2048;
   localparam logic [11:0] ZEROS_T1       = 12'd192;
   localparam logic [7:0]  ONES_WINDOW    = 8'd255;
   localparam logic [7:0]  ONES_TO_CLEAR  = 8'd32;

   // one channel time (eight bit periods) and the system clock
   localparam int CLK_PERIOD_NS = 40;
   localparam int T1_CHAN_NS    = 5184;
   localparam int E1_CHAN_NS    = 3904;
   localparam logic [7:0] T1_CHAN_CYC =
      8'((T1_CHAN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] E1_CHAN_CYC =
      8'((E1_CHAN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // multiframes with distant alarm bit set before the alarm
   localparam logic [1:0] DMA_RUN = 2'd2;

   // live receive conditions reported by the framer
   typedef struct packed {
      logic spare_code;
      logic loop_down;
      logic loop_up;
      logic v5_link;
      logic remote_alarm;
      logic yellow;
      logic all_ones;
      logic sync_loss;
   } lasi_cond_t;

   // one-cycle frame and signaling events from the framer
   typedef struct packed {
      logic ais_ci;
      logic sig_ones;
      logic sig_zeros;
      logic tx_mf;
      logic tx_align;
      logic rx_mf;
      logic rx_crc_mf;
      logic rx_align;
   } lasi_evt_t;

endpackage : lasi_pkg

// *** lasi_status_irq.sv ***
// Summary of operation
// - clock select bit: 0 pin, 1 system clock
// - identity: revision low nibble, device id high
// - sync loss bit follows framer sync state
// - carrier loss after 255/2048/192 zero run
// - all-ones live; yellow live in T1 only
// - sync regained latched until status read
// - clear events on condition end; yellow T1
// - first register masks: rising edge interrupts low nibble, clear event interrupts high nibble
// - second register masks: both edge interrupts
// - distant alarm after two consecutive set multiframes
// - E1 remote alarm and V5.2 link conditions
// - receive clock loss after one idle channel
// - transmit clock loss, drives shared pin high when pin function bit is 1
// - T1 loop up, down, spare code conditions
// - E1 receive align frame event latched
// - E1 transmit align frame event latched
// - E1 CRC-4 multiframe event latched
// - receive multiframe event latched
// - transmit multiframe event latched
// - E1 signaling all-zeros and all-ones events
// - T1 AIS-CI event latched
// - third mask enables each frame event interrupt
module lasi_status_irq #(
   parameter logic [3:0] DIE_REVISION = 4'h1, // arbitrary value
   parameter logic [3:0] DEVICE_CODE  = 4'h5  // arbitrary value
) (
   // clock, reset, enable
   input  wire logic               clk_sys,
   input  wire logic               nrst,
   input  wire logic               ce,
   // host port
   input  wire logic [7:0]         host_addr,
   input  wire logic               host_wr,
   input  wire logic               host_rd,
   input  wire logic [7:0]         host_wdata,
   output logic      [7:0]         host_rdata_q,
   // mode straps from the framer configuration
   input  wire logic               e1_mode,
   input  wire logic               e1_carrier_2048,
   // framer detection inputs
   input  wire lasi_pkg::lasi_cond_t framer_cond,
   input  wire lasi_pkg::lasi_evt_t  framer_evt,
   input  wire logic               mf_ts16_valid,
   input  wire logic               mf_ts16_bit6,
   // line and clock pins
   input  wire logic               rx_positive_rail_in,
   input  wire logic               rx_negative_rail_in,
   input  wire logic               rx_line_clock_in,
   input  wire logic               tx_line_clock,
   input  wire logic               tx_system_clock_pin,
   input  wire logic               master_clock_pin,
   // outputs
   output logic                    master_clock_out_q,
   output logic                    shared_alarm_pin_q,
   output logic                    irq_n_q
);

   // pin synchroniser bit positions
   localparam int P_RPOS = 0;
   localparam int P_RNEG = 1;
   localparam int P_RCLK = 2;
   localparam int P_TX_LINE_CLOCK = 3;
   localparam int P_TSYS = 4;
   localparam int P_MCLK = 5;

   logic [5:0]  pin_s1_q;
   logic [5:0]  pin_s2_q;
   logic [1:0]  clk_prev_q;
   logic [7:0]  mask_a_q;
   logic [7:0]  mask_b_q;
   logic [7:0]  mask_c_q;
   logic        mclk_sel_q;
   logic        pin_func_q;
   logic [11:0] zero_run_q;
   logic [7:0]  win_cnt_q;
   logic [7:0]  ones_cnt_q;
   logic        carrier_loss_q;
   logic [7:0]  idle_cnt_q [2];
   logic [1:0]  clk_loss_q;
   logic [1:0]  dma_cnt_q;
   logic        distant_mf_q;
   logic [3:0]  cond_a_prev_q;
   logic [7:0]  cond_b_prev_q;
   logic [3:0]  evt_a_q;
   logic [3:0]  pend_a_q;
   logic [7:0]  pend_b_q;
   logic [7:0]  evt_c_q;
   logic        rx_bit_tick;
   logic        rx_zero_bit;
   logic [11:0] zero_limit;
   logic [7:0]  chan_limit;
   logic [1:0]  clk_edge;
   logic [3:0]  cond_a;
   logic [7:0]  cond_b;
   logic [3:0]  evt_a_set;
   logic [7:0]  evt_c_set;
   logic        rd_status_a;
   logic        rd_status_b;
   logic        rd_frame_evt;
   logic        irq_any;
   logic [7:0]  rd_mux;

   // two-stage synchronisers for every pin
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pin_s1_q <= 6'h00;
         pin_s2_q <= 6'h00;
      end else if (ce) begin
         pin_s1_q <= {master_clock_pin, tx_system_clock_pin, tx_line_clock,
                      rx_line_clock_in, rx_negative_rail_in,
                      rx_positive_rail_in};
         pin_s2_q <= pin_s1_q;
      end
   end

   // previous synchronised line clocks for edge detection
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         clk_prev_q <= 2'h0;
      end else if (ce) begin
         clk_prev_q <= {pin_s2_q[P_TX_LINE_CLOCK], pin_s2_q[P_RCLK]};
      end
   end

   // line clock edges, receive bit tick and zero bit on the rails
   assign clk_edge    = clk_prev_q ^ {pin_s2_q[P_TX_LINE_CLOCK], pin_s2_q[P_RCLK]};
   assign rx_bit_tick = pin_s2_q[P_RCLK] & ~clk_prev_q[0];
   assign rx_zero_bit = ~pin_s2_q[P_RPOS] & ~pin_s2_q[P_RNEG];

   // zero-run threshold by line mode and E1 option
   always_comb begin
      if (!e1_mode) begin
         zero_limit = lasi_pkg::ZEROS_T1;
      end else if (e1_carrier_2048) begin
         zero_limit = lasi_pkg::ZEROS_E1_LONG;
      end else begin
         zero_limit = lasi_pkg::ZEROS_E1_SHORT;
      end
      chan_limit = e1_mode ? lasi_pkg::E1_CHAN_CYC : lasi_pkg::T1_CHAN_CYC;
   end

   // consecutive zero counter, saturating at the long threshold
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         zero_run_q <= 12'h000;
      end else if (ce && rx_bit_tick) begin
         if (!rx_zero_bit) begin
            zero_run_q <= 12'h000;
         end else if (zero_run_q != lasi_pkg::ZEROS_E1_LONG) begin
            zero_run_q <= zero_run_q + 12'h001;
         end
      end
   end

   // ones density window used to leave carrier loss
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         win_cnt_q  <= 8'h00;
         ones_cnt_q <= 8'h00;
      end else if (ce && rx_bit_tick) begin
         if (win_cnt_q == lasi_pkg::ONES_WINDOW - 8'h01) begin
            win_cnt_q  <= 8'h00;
            ones_cnt_q <= 8'h00;
         end else begin
            win_cnt_q <= win_cnt_q + 8'h01;
            if (!rx_zero_bit && ones_cnt_q != lasi_pkg::ONES_TO_CLEAR) begin
               ones_cnt_q <= ones_cnt_q + 8'h01;
            end
         end
      end
   end

   // carrier loss condition
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         carrier_loss_q <= 1'b0;
      end else if (ce && rx_bit_tick) begin
         if (rx_zero_bit && zero_run_q + 12'h001 >= zero_limit) begin
            carrier_loss_q <= 1'b1;
         end else if (ones_cnt_q == lasi_pkg::ONES_TO_CLEAR) begin
            carrier_loss_q <= 1'b0;
         end
      end
   end

   // idle counters on receive (0) and transmit (1) line clocks
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         for (int i = 0; i < 2; i++) begin
            idle_cnt_q[i] <= 8'h00;
            clk_loss_q[i] <= 1'b0;
         end
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            if (clk_edge[i]) begin
               idle_cnt_q[i] <= 8'h00;
               clk_loss_q[i] <= 1'b0;
            end else if (idle_cnt_q[i] >= chan_limit) begin
               clk_loss_q[i] <= 1'b1;
            end else begin
               idle_cnt_q[i] <= idle_cnt_q[i] + 8'h01;
            end
         end
      end
   end

   // distant multiframe alarm from time slot 16 frame 0 bit 6
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         dma_cnt_q    <= 2'h0;
         distant_mf_q <= 1'b0;
      end else if (ce && mf_ts16_valid) begin
         if (!mf_ts16_bit6) begin
            dma_cnt_q    <= 2'h0;
            distant_mf_q <= 1'b0;
         end else if (dma_cnt_q + 2'h1 >= lasi_pkg::DMA_RUN) begin
            dma_cnt_q    <= lasi_pkg::DMA_RUN;
            distant_mf_q <= 1'b1;
         end else begin
            dma_cnt_q <= dma_cnt_q + 2'h1;
         end
      end
   end

   // live condition vectors with line mode gating
   always_comb begin
      cond_a = {framer_cond.yellow & ~e1_mode,
                framer_cond.all_ones,
                carrier_loss_q,
                framer_cond.sync_loss};
      cond_b = {framer_cond.spare_code & ~e1_mode,
                framer_cond.loop_down & ~e1_mode,
                framer_cond.loop_up & ~e1_mode,
                clk_loss_q[1],
                clk_loss_q[0],
                framer_cond.v5_link & e1_mode,
                distant_mf_q & e1_mode,
                framer_cond.remote_alarm & e1_mode};
   end

   // events in the first status register: ends of conditions
   always_comb begin
      evt_a_set = cond_a_prev_q & ~cond_a;
   end

   // frame events with line mode gating
   always_comb begin
      evt_c_set = {framer_evt.ais_ci & ~e1_mode,
                   framer_evt.sig_ones & e1_mode,
                   framer_evt.sig_zeros & e1_mode,
                   framer_evt.tx_mf,
                   framer_evt.tx_align & e1_mode,
                   framer_evt.rx_mf,
                   framer_evt.rx_crc_mf & e1_mode,
                   framer_evt.rx_align & e1_mode};
   end

   // previous condition values for edge detection
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cond_a_prev_q <= 4'h0;
         cond_b_prev_q <= 8'h00;
      end else if (ce) begin
         cond_a_prev_q <= cond_a;
         cond_b_prev_q <= cond_b;
      end
   end

   // read strobes that clear latched bits
   assign rd_status_a  = host_rd && host_addr == lasi_pkg::ADDR_STATUS_A;
   assign rd_status_b  = host_rd && host_addr == lasi_pkg::ADDR_STATUS_B;
   assign rd_frame_evt = host_rd && host_addr == lasi_pkg::ADDR_FRAME_EVT;

   // latched events; a new event wins over the clearing read
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         evt_a_q <= lasi_pkg::RESET_REG[3:0];
         evt_c_q <= lasi_pkg::RESET_REG;
      end else if (ce) begin
         evt_a_q <= (rd_status_a ? 4'h0 : evt_a_q) | evt_a_set;
         evt_c_q <= (rd_frame_evt ? 8'h00 : evt_c_q) | evt_c_set;
      end
   end

   // pending interrupts of the condition bits
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pend_a_q <= 4'h0;
         pend_b_q <= 8'h00;
      end else if (ce) begin
         pend_a_q <= (rd_status_a ? 4'h0 : pend_a_q) |
                     (cond_a & ~cond_a_prev_q & mask_a_q[3:0]);
         pend_b_q <= (rd_status_b ? 8'h00 : pend_b_q) |
                     ((cond_b ^ cond_b_prev_q) & mask_b_q);
      end
   end

   // writable mask and control registers
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         mask_a_q   <= lasi_pkg::RESET_REG;
         mask_b_q   <= lasi_pkg::RESET_REG;
         mask_c_q   <= lasi_pkg::RESET_REG;
         mclk_sel_q <= 1'b0;
         pin_func_q <= 1'b0;
      end else if (ce && host_wr) begin
         case (host_addr)
            lasi_pkg::ADDR_MASK_A: begin
               mask_a_q <= host_wdata;
            end
            lasi_pkg::ADDR_MASK_B: begin
               mask_b_q <= host_wdata;
            end
            lasi_pkg::ADDR_FRAME_MASK: begin
               mask_c_q <= host_wdata;
            end
            lasi_pkg::ADDR_COMMON_ONE: begin
               mclk_sel_q <= host_wdata[lasi_pkg::CCR_MCLK_SEL_BIT];
               pin_func_q <= host_wdata[lasi_pkg::CCR_PIN_FUNC_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // read data selection
   always_comb begin
      case (host_addr)
         lasi_pkg::ADDR_IDENTITY:   rd_mux = {DEVICE_CODE, DIE_REVISION};
         lasi_pkg::ADDR_STATUS_A:   rd_mux = {evt_a_q, cond_a};
         lasi_pkg::ADDR_MASK_A:     rd_mux = mask_a_q;
         lasi_pkg::ADDR_STATUS_B:   rd_mux = cond_b;
         lasi_pkg::ADDR_MASK_B:     rd_mux = mask_b_q;
         lasi_pkg::ADDR_FRAME_EVT:  rd_mux = evt_c_q;
         lasi_pkg::ADDR_FRAME_MASK: rd_mux = mask_c_q;
         lasi_pkg::ADDR_COMMON_ONE: rd_mux = {mclk_sel_q, 6'h00, pin_func_q};
         default:                   rd_mux = lasi_pkg::UNMAPPED_RD;
      endcase
   end

   // registered read data, captured on the read strobe
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         host_rdata_q <= 8'h00;
      end else if (ce && host_rd) begin
         host_rdata_q <= rd_mux;
      end
   end

   // single interrupt from all pending and enabled sources
   assign irq_any = |pend_a_q | |pend_b_q |
                    |(evt_a_q & mask_a_q[7:4]) |
                    |(evt_c_q & mask_c_q);

   // registered active-low interrupt output
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irq_n_q <= 1'b1;
      end else if (ce) begin
         irq_n_q <= ~irq_any;
      end
   end

   // master clock source and shared alarm pin
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         master_clock_out_q <= 1'b0;
         shared_alarm_pin_q <= 1'b0;
      end else if (ce) begin
         master_clock_out_q <= mclk_sel_q ? pin_s2_q[P_TSYS]
                                          : pin_s2_q[P_MCLK];
         shared_alarm_pin_q <= pin_func_q ? clk_loss_q[1]
                                          : framer_cond.sync_loss;
      end
   end

endmodule : lasi_status_irq

// *** lasi_assertions.sv ***
module lasi_assertions #(
   parameter logic [3:0] DIE_REVISION = 4'h1,
   parameter logic [3:0] DEVICE_CODE  = 4'h5
) (
   // clock and reset
   input wire logic                 clk_sys,
   input wire logic                 nrst,
   input wire logic                 ce,
   // host port
   input wire logic [7:0]           host_addr,
   input wire logic                 host_wr,
   input wire logic                 host_rd,
   input wire logic [7:0]           host_wdata,
   input wire logic [7:0]           host_rdata_q,
   // framer side
   input wire logic                 e1_mode,
   input wire lasi_pkg::lasi_cond_t framer_cond,
   input wire lasi_pkg::lasi_evt_t  framer_evt,
   input wire logic                 tx_system_clock_pin,
   input wire logic                 master_clock_pin,
   // outputs
   input wire logic                 master_clock_out_q,
   input wire logic                 shared_alarm_pin_q,
   input wire logic                 irq_n_q
);
   default clocking dc @(posedge clk_sys);
   endclocking

   logic [7:0] ma_q, mb_q, mf_q, ctl_q;
   logic       armed_q;
   logic       rd_ok;
   assign rd_ok = ce && host_rd;

   // shadow copies of the mask and control registers
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ma_q  <= 8'h00;
         mb_q  <= 8'h00;
         mf_q  <= 8'h00;
         ctl_q <= 8'h00;
      end else if (ce && host_wr) begin
         if (host_addr == lasi_pkg::ADDR_MASK_A) ma_q <= host_wdata;
         if (host_addr == lasi_pkg::ADDR_MASK_B) mb_q <= host_wdata;
         if (host_addr == lasi_pkg::ADDR_FRAME_MASK) mf_q <= host_wdata;
         if (host_addr == lasi_pkg::ADDR_COMMON_ONE) ctl_q <= host_wdata;
      end
   end

   // set once any mask has been opened since reset
   always_ff @(posedge clk_sys) begin
      if (!nrst) armed_q <= 1'b0;
      else if (|{ma_q, mb_q, mf_q}) armed_q <= 1'b1;
   end

   AST_RESET_OUT: assert property (disable iff (1'b0)
      !nrst && ce |=> irq_n_q && host_rdata_q == 8'h00)
      else $error("outputs not at reset level");
   AST_ID_READ: assert property (disable iff (!nrst)
      rd_ok && host_addr == lasi_pkg::ADDR_IDENTITY
      |=> host_rdata_q == {DEVICE_CODE, DIE_REVISION})
      else $error("identity read wrong");
   AST_MASK_RB: assert property (disable iff (!nrst)
      ce && host_wr && host_addr == lasi_pkg::ADDR_FRAME_MASK ##2
      rd_ok && host_addr == lasi_pkg::ADDR_FRAME_MASK
      |=> host_rdata_q == $past(host_wdata, 3))
      else $error("frame mask read back wrong");
   AST_QUIET: assert property (disable iff (!nrst)
      !armed_q |-> irq_n_q)
      else $error("interrupt with all masks closed");
   AST_RISE_IRQ: assert property (disable iff (!nrst)
      ma_q[0] && $rose(framer_cond.sync_loss) |-> ##[1:3] !irq_n_q)
      else $error("no interrupt on condition rise");
   AST_REGAIN_IRQ: assert property (disable iff (!nrst)
      ma_q[4] && $fell(framer_cond.sync_loss) |-> ##[1:3] !irq_n_q)
      else $error("no interrupt on sync regained");
   AST_BOTH_EDGE: assert property (disable iff (!nrst)
      mb_q[0] && e1_mode && $changed(framer_cond.remote_alarm)
      |-> ##[1:3] !irq_n_q)
      else $error("no interrupt on remote alarm edge");
   AST_FRAME_IRQ: assert property (disable iff (!nrst)
      (framer_evt.rx_mf && mf_q[2]) || (framer_evt.tx_mf && mf_q[4])
      |-> ##[1:3] !irq_n_q)
      else $error("no interrupt on multiframe event");
   AST_SHARED_PIN: assert property (disable iff (!nrst)
      !ctl_q[0] ##0 $stable(framer_cond.sync_loss) [*5]
      |-> shared_alarm_pin_q == framer_cond.sync_loss)
      else $error("shared pin does not follow sync loss");
   AST_MCLK_SEL: assert property (disable iff (!nrst)
      $stable({ctl_q[7], tx_system_clock_pin, master_clock_pin}) [*5]
      |-> master_clock_out_q ==
          (ctl_q[7] ? tx_system_clock_pin : master_clock_pin))
      else $error("master clock source wrong");

   COV_REGAIN: cover property (disable iff (!nrst)
      ma_q[4] && $fell(framer_cond.sync_loss));
   COV_BOTH: cover property (disable iff (!nrst)
      mb_q[0] && e1_mode && $fell(framer_cond.remote_alarm));
   COV_FRAME: cover property (disable iff (!nrst)
      framer_evt.tx_mf && mf_q[4]);
endmodule : lasi_assertions

bind lasi_status_irq lasi_assertions #(
   .DIE_REVISION(DIE_REVISION),
   .DEVICE_CODE(DEVICE_CODE)
) u_chk (
   .clk_sys, .nrst, .ce, .host_addr, .host_wr, .host_rd, .host_wdata,
   .host_rdata_q, .e1_mode, .framer_cond, .framer_evt,
   .tx_system_clock_pin, .master_clock_pin, .master_clock_out_q,
   .shared_alarm_pin_q, .irq_n_q
);

// *** test_line_alarm_status_irq.sv ***
module test_line_alarm_status_irq;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [3:0] REV = 4'h3; // arbitrary value
   localparam logic [3:0] DEV = 4'h9; // arbitrary value
   logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, host_rdata_q;
   logic clk_sys = 0, nrst = 0, ce = 1, host_wr = 0, host_rd = 0;
   logic e1_mode = 0, e1_carrier_2048 = 0;
   lasi_pkg::lasi_cond_t framer_cond = '0;
   lasi_pkg::lasi_evt_t  framer_evt = '0;
   logic mf_ts16_valid = 0, mf_ts16_bit6 = 0;
   logic rx_positive_rail_in = 1, rx_negative_rail_in = 0;
   logic rx_line_clock_in = 0, tx_line_clock = 0, run_rx = 1, run_tx = 1;
   logic tx_system_clock_pin = 0, master_clock_pin = 0;
   logic master_clock_out_q, shared_alarm_pin_q, irq_n_q;
   int   err_total = 0, cmp_count = 0;

   lasi_status_irq #(.DIE_REVISION(REV), .DEVICE_CODE(DEV)) i_dut (
      .clk_sys, .nrst, .ce, .host_addr, .host_wr, .host_rd, .host_wdata,
      .host_rdata_q, .e1_mode, .e1_carrier_2048, .framer_cond, .framer_evt,
      .mf_ts16_valid, .mf_ts16_bit6, .rx_positive_rail_in,
      .rx_negative_rail_in, .rx_line_clock_in, .tx_line_clock,
      .tx_system_clock_pin, .master_clock_pin, .master_clock_out_q,
      .shared_alarm_pin_q, .irq_n_q);

   // system clock and free line clocks of unrelated phase
   always #20 clk_sys = ~clk_sys;
   // offsets keep the line clock edges off both system clock edges
   initial #10 forever #60 if (run_rx) rx_line_clock_in = ~rx_line_clock_in;
   initial #2 forever #52 if (run_tx) tx_line_clock = ~tx_line_clock;

   task automatic chk(input string what, input logic [7:0] e, g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : wt

   task automatic wr(input logic [7:0] a, d);
      @(negedge clk_sys);
      host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      @(negedge clk_sys);
      host_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, e);
      @(negedge clk_sys);
      host_addr = a;
      host_rd = 1'b1;
      @(negedge clk_sys);
      host_rd = 1'b0;
      chk($sformatf("reg_%h", a), e, host_rdata_q);
   endtask : rd

   task automatic irq(input logic e);
      wt(4);
      chk("irq_n", {7'h00, e}, {7'h00, irq_n_q});
   endtask : irq

   task automatic t_regs;
      logic [7:0] a[6] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d};
      foreach (a[i]) rd(a[i], 8'h00);
      rd(8'h0f, {DEV, REV});
      wr(8'h0f, 8'h00);
      rd(8'h0f, {DEV, REV});
      rd(8'h20, 8'h00);
      for (int i = 1; i < 6; i += 2) begin
         wr(a[i], 8'ha5);
         rd(a[i], 8'ha5);
         wr(a[i], 8'h00);
      end
      $display("test regs done, errors %0d", err_total);
   endtask : t_regs

   task automatic t_sync;
      wr(8'h19, 8'h11);
      framer_cond.sync_loss = 1'b1;
      irq(1'b0);
      rd(8'h18, 8'h01);
      irq(1'b1);
      framer_cond.sync_loss = 1'b0;
      irq(1'b0);
      rd(8'h18, 8'h10);
      irq(1'b1);
      rd(8'h18, 8'h00);
      wr(8'h19, 8'h04);
      framer_cond.all_ones = 1'b1;
      irq(1'b0);
      rd(8'h18, 8'h04);
      irq(1'b1);
      framer_cond.all_ones = 1'b0;
      irq(1'b1);
      rd(8'h18, 8'h40);
      framer_cond.yellow = 1'b1;
      rd(8'h18, 8'h08);
      framer_cond.yellow = 1'b0;
      rd(8'h18, 8'h80);
      wr(8'h19, 8'h00);
      $display("test sync and edges done, errors %0d", err_total);
   endtask : t_sync

   task automatic t_both;
      e1_mode = 1'b1;
      wr(8'h1b, 8'h01);
      framer_cond.remote_alarm = 1'b1;
      irq(1'b0);
      rd(8'h1a, 8'h01);
      irq(1'b1);
      framer_cond.remote_alarm = 1'b0;
      irq(1'b0);
      rd(8'h1a, 8'h00);
      irq(1'b1);
      framer_cond.v5_link = 1'b1;
      rd(8'h1a, 8'h04);
      framer_cond.v5_link = 1'b0;
      e1_mode = 1'b0;
      framer_cond[7:5] = 3'b111;
      rd(8'h1a, 8'he0);
      framer_cond[7:5] = 3'b000;
      wr(8'h1b, 8'h00);
      $display("test second register done, errors %0d", err_total);
   endtask : t_both

   task automatic t_evt;
      wr(8'h1d, 8'hff);
      for (int i = 0; i < 9; i++) begin
         if (i == 8) wr(8'h1d, 8'hfe);
         e1_mode = (i != 7);
         framer_evt = lasi_pkg::lasi_evt_t'(8'h01 << (i % 8));
         wt(1);
         framer_evt = '0;
         irq(i == 8);
         rd(8'h1c, 8'h01 << (i % 8));
         irq(1'b1);
      end
      e1_mode = 1'b0;
      framer_evt = lasi_pkg::lasi_evt_t'(8'h01);
      wt(1);
      framer_evt = '0;
      rd(8'h1c, 8'h00);
      wr(8'h1d, 8'h00);
      // an event while the clock enable is low must not latch
      ce = 1'b0;
      framer_evt = lasi_pkg::lasi_evt_t'(8'h10);
      wt(1);
      framer_evt = '0;
      ce = 1'b1;
      rd(8'h1c, 8'h00);
      $display("test frame events done, errors %0d", err_total);
   endtask : t_evt

   task automatic t_carrier;
      int n[3] = '{192, 255, 2048};
      for (int i = 0; i < 3; i++) begin
         e1_mode = (i != 0);
         e1_carrier_2048 = (i == 2);
         rx_positive_rail_in = 1'b0;
         wt((n[i] - 12) * 3);
         rd(8'h18, 8'h00);
         wt(90);
         rd(8'h18, 8'h02);
         rx_positive_rail_in = 1'b1;
         wt(240);
         rd(8'h18, 8'h20);
      end
      e1_mode = 1'b0;
      $display("test carrier loss done, errors %0d", err_total);
   endtask : t_carrier

   task automatic t_clk;
      wr(8'h70, 8'h01);
      run_tx = 1'b0;
      wt(200);
      rd(8'h1a, 8'h10);
      chk("shared_pin", 8'h01, {7'h00, shared_alarm_pin_q});
      run_tx = 1'b1;
      run_rx = 1'b0;
      wt(200);
      rd(8'h1a, 8'h08);
      run_rx = 1'b1;
      wt(20);
      rd(8'h1a, 8'h00);
      for (int i = 0; i < 4; i++) begin
         tx_system_clock_pin = i[0];
         master_clock_pin = ~i[0];
         wr(8'h70, {i[1], 7'h00});
         wt(6);
         chk("mclk", {7'h00, i[1] ~^ i[0]}, {7'h00, master_clock_out_q});
      end
      e1_mode = 1'b1;
      mf_ts16_bit6 = 1'b1;
      for (int i = 0; i < 2; i++) begin
         mf_ts16_valid = 1'b1;
         wt(1);
         mf_ts16_valid = 1'b0;
         rd(8'h1a, (i == 1) ? 8'h02 : 8'h00);
      end
      $display("test clocks and distant alarm done, errors %0d", err_total);
   endtask : t_clk

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   // main sequence
   initial begin
      wt(3);
      nrst = 1'b1;
      t_regs();
      t_sync();
      t_both();
      t_evt();
      t_carrier();
      t_clk();
      tally_and_finish();
   end

   // watchdog against a hang
   initial begin
      repeat (40000) @(posedge clk_sys);
      err_total++;
      $display("mismatch watchdog expected end seen hang");
      tally_and_finish();
   end
endmodule : test_line_alarm_status_irq
